// ===== verilog/reset_seq_consts.svh
/*
 * Offsets, field positions, reset values and cycle counts of the reset sequencer.
 * Assumes a 10 MHz oscillator clock; every count is in oscillator cycles.
 */
`ifndef RESET_SEQ_CONSTS_SVH
`define RESET_SEQ_CONSTS_SVH

// register byte offsets on the bus
`define OFS_FLAGS        4'h0
`define OFS_CTRL         4'h4
`define OFS_STATUS       4'h8

// reset_cause_flags bit positions
`define FLAG_POR         7
`define FLAG_PIN         6
`define FLAG_WDOG        5
`define FLAG_ILLEGAL_OPCODE_FLAG        4
`define FLAG_ILLEGAL_ADDRESS_FLAG        3
`define FLAG_MON         2
`define FLAG_LVI         1
`define FLAGS_RST        8'h80

// control register fields
`define CTRL_STOP_EN     0
`define CTRL_DIV_LO      1
`define CTRL_DIV_HI      2

// sequence counts in oscillator cycles
`define DRIVE_CYCLES     32
`define HOLD_CYCLES      32
`define STAB_CYCLES      4096
`define EXT_MIN_CYCLES   4

// cpu memory map points
`define RESET_VECTOR     16'hFFFE
`define WDOG_ADDR        16'hFFFF

`endif

// ===== verilog/reset_seq_pkg.sv
/*
 * Types of the reset sequencer: sequence states, bus clock divide codes and
 * the cpu strobe bundle. Assumes reset_seq_consts.svh for numeric constants.
 */
package reset_seq_pkg;

    typedef enum logic [1:0] {
        div_by_1,
        div_by_2,
        div_by_4,
        div_by_8
    } bus_div_e;

    typedef enum logic [2:0] {
        s_run,
        s_stab,
        s_lowv,
        s_drive,
        s_hold,
        s_ext
    } seq_state_e;

    // one cycle strobes from the processor core, same clock
    typedef struct packed {
        logic        opcode_fetch;
        logic        data_write;
        logic        illegal_opcode;
        logic        stop_opcode;
        logic        unmapped;
        logic [15:0] address;
    } cpu_bus_s;

endpackage : reset_seq_pkg

// ===== verilog/reset_source_sequencer.sv
/*
 * Reset sequencer and reset-source log: drives the shared active-low reset pin,
 * gates clocks through the stabilization delay, releases the processor to its
 * reset vector and keeps the clear-on-read reset_cause_flags register.
 * Assumes: sys_rst_in is the power-on reset, clock_in is the oscillator clock,
 * cpu strobes are synchronous, the reset pin and supply detector are not.
 */
// Implementation choices: the register addresses and the Avalon-MM slave port.
`include "reset_seq_consts.svh"

module reset_source_sequencer #(
    parameter int unsigned WDOG_LIMIT = 262144
) (
    // clock and power-on reset
    input  wire logic                   clock_in,
    input  wire logic                   sys_rst_in,
    // avalon-mm slave
    input  wire logic [3:0]             avs_address_in,
    input  wire logic                   avs_read_in,
    input  wire logic                   avs_write_in,
    input  wire logic [31:0]            avs_writedata_in,
    input  wire logic [3:0]             avs_byteenable_in,
    output logic      [31:0]            avs_readdata_out,
    output logic                        avs_waitrequest_out,
    // shared reset pin, open drain
    input  wire logic                   reset_pin_n_in,
    output logic                        reset_pin_n_out,
    output logic                        reset_pin_oe_out,
    // supply detector and monitor entry
    input  wire logic                   supply_low_in,
    input  wire logic                   monitor_entry_in,
    // processor side
    input  wire reset_seq_pkg::cpu_bus_s cpu_bus_in,
    output logic                        cpu_reset_out,
    output logic                        clocks_gated_out,
    output logic                        vector_fetch_out,
    output logic      [15:0]            vector_addr_out,
    output reset_seq_pkg::bus_div_e     bus_div_out
);
    import reset_seq_pkg::*;

    localparam logic [11:0] DRIVE_LAST = 12'(`DRIVE_CYCLES - 1);
    localparam logic [11:0] HOLD_LAST  = 12'(`HOLD_CYCLES - 1);
    localparam logic [11:0] STAB_LAST  = 12'(`STAB_CYCLES - 1);
    localparam logic [2:0]  EXT_LAST   = 3'(`EXT_MIN_CYCLES - 1);
    localparam logic [17:0] WDOG_LAST  = 18'(WDOG_LIMIT - 1);

    seq_state_e  state_r, state_nxt;
    logic [11:0] cnt_r, cnt_nxt;
    logic [2:0]  ext_len_r;
    logic [17:0] wdog_cnt_r;
    logic [7:0]  flags_r, set_vec;
    logic        stop_en_r;
    logic        int_path_r;
    logic        pin_meta_r, pin_sync_r;
    logic        lv_meta_r, lv_sync_r;
    logic        pin_oe_r, pin_out_r, cpu_reset_r, gate_r, vfetch_r;
    bus_div_e    bus_div_r;
    logic        wait_r;
    logic [31:0] rdata_r;
    logic        req, accept, rd_clr;
    logic        wdog_over, illegal_opcode_flag_evt, illegal_address_flag_evt, mon_evt, int_evt, ext_evt;
    logic        lv_entry, hold_done, late_pin;

    // the first stage is read only by the second
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pin_meta_r <= 1'b1;
            pin_sync_r <= 1'b1;
            lv_meta_r  <= 1'b0;
            lv_sync_r  <= 1'b0;
        end else begin
            pin_meta_r <= reset_pin_n_in;
            pin_sync_r <= pin_meta_r;
            lv_meta_r  <= supply_low_in;
            lv_sync_r  <= lv_meta_r;
        end
    end

    // reset sources other than low supply, only while the cpu runs
    assign wdog_over = (state_r == s_run) && (wdog_cnt_r == WDOG_LAST);
    assign illegal_opcode_flag_evt  = (state_r == s_run) && cpu_bus_in.opcode_fetch
                     && (cpu_bus_in.illegal_opcode
                         || (cpu_bus_in.stop_opcode && !stop_en_r));
    // data accesses are not looked at for unmapped addresses
    assign illegal_address_flag_evt  = (state_r == s_run) && cpu_bus_in.opcode_fetch && cpu_bus_in.unmapped;
    assign mon_evt   = (state_r == s_run) && monitor_entry_in;
    assign int_evt   = wdog_over || illegal_opcode_flag_evt || illegal_address_flag_evt || mon_evt;
    assign ext_evt   = (state_r == s_run) && !pin_sync_r && (ext_len_r == EXT_LAST);
    assign lv_entry  = lv_sync_r && (state_r != s_lowv);
    assign hold_done = (state_r == s_hold) && (cnt_r == HOLD_LAST);
    // pin sampled 32 cycles after our own release
    assign late_pin  = hold_done && int_path_r && !pin_sync_r;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r + 12'h001;
        unique case (state_r)
            s_run: begin
                cnt_nxt = 12'h000;
                if (int_evt) begin
                    state_nxt = s_drive;
                end else if (ext_evt) begin
                    state_nxt = s_ext;
                end
            end
            s_stab: begin
                if (cnt_r == STAB_LAST) begin
                    state_nxt = s_drive;
                    cnt_nxt   = 12'h000;
                end
            end
            s_lowv: begin
                cnt_nxt = 12'h000;
                if (!lv_sync_r) begin
                    state_nxt = s_stab;
                end
            end
            s_drive: begin
                if (cnt_r == DRIVE_LAST) begin
                    state_nxt = s_hold;
                    cnt_nxt   = 12'h000;
                end
            end
            s_hold: begin
                if (hold_done) begin
                    state_nxt = s_run;
                    cnt_nxt   = 12'h000;
                end
            end
            s_ext: begin
                cnt_nxt = 12'h000;
                if (pin_sync_r) begin
                    state_nxt = s_hold;
                end
            end
        endcase
        // low supply overrides any step, even mid sequence
        if (lv_sync_r) begin
            state_nxt = s_lowv;
            cnt_nxt   = 12'h000;
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_r <= s_stab;
            cnt_r   <= 12'h000;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // which kind of sequence is running, for the late pin sample
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            int_path_r <= 1'b1;
        end else if (state_nxt == s_ext) begin
            int_path_r <= 1'b0;
        end else if (state_nxt == s_drive || state_nxt == s_lowv) begin
            int_path_r <= 1'b1;
        end
    end

    // minimum low time before the pin counts as an external reset
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ext_len_r <= 3'h0;
        end else if (state_r != s_run || pin_sync_r) begin
            ext_len_r <= 3'h0;
        end else if (ext_len_r != EXT_LAST) begin
            ext_len_r <= ext_len_r + 3'h1;
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wdog_cnt_r <= 18'h0_0000;
        end else if (state_r != s_run
                     || (cpu_bus_in.data_write && cpu_bus_in.address == `WDOG_ADDR)) begin
            wdog_cnt_r <= 18'h0_0000;
        end else begin
            wdog_cnt_r <= wdog_cnt_r + 18'h0_0001;
        end
    end

    // outputs follow the next state so they line up with it
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pin_oe_r    <= 1'b1;
            pin_out_r   <= 1'b0;
            cpu_reset_r <= 1'b1;
            gate_r      <= 1'b1;
            vfetch_r    <= 1'b0;
        end else begin
            pin_oe_r    <= (state_nxt == s_stab) || (state_nxt == s_lowv)
                           || (state_nxt == s_drive);
            pin_out_r   <= 1'b0;
            cpu_reset_r <= (state_nxt != s_run);
            gate_r      <= (state_nxt == s_stab);
            vfetch_r    <= (state_r != s_run) && (state_nxt == s_run);
        end
    end

    // software choice of bus clock, overridden by any reset
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            bus_div_r <= div_by_4;
            stop_en_r <= 1'b0;
        end else if (state_nxt != s_run) begin
            bus_div_r <= div_by_4;
        end else if (accept && avs_write_in && avs_address_in == `OFS_CTRL && avs_byteenable_in[0]) begin
            bus_div_r <= bus_div_e'(avs_writedata_in[`CTRL_DIV_HI:`CTRL_DIV_LO]);
            stop_en_r <= avs_writedata_in[`CTRL_STOP_EN];
        end
    end

    // set wins over the read clear; only bits already returned are cleared
    always_comb begin
        set_vec = 8'h00;
        set_vec[`FLAG_PIN]  = ext_evt || late_pin;
        set_vec[`FLAG_WDOG] = wdog_over;
        set_vec[`FLAG_ILLEGAL_OPCODE_FLAG] = illegal_opcode_flag_evt;
        set_vec[`FLAG_ILLEGAL_ADDRESS_FLAG] = illegal_address_flag_evt;
        set_vec[`FLAG_MON]  = mon_evt;
        set_vec[`FLAG_LVI]  = lv_entry;
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            flags_r <= `FLAGS_RST;
        end else if (rd_clr) begin
            flags_r <= (flags_r & ~rdata_r[7:0]) | set_vec;
        end else begin
            flags_r <= flags_r | set_vec;
        end
    end

    // bus slave: one wait cycle, data prepared while waitrequest is high
    assign req    = avs_read_in || avs_write_in;
    assign accept = req && !wait_r;
    assign rd_clr = accept && avs_read_in && (avs_address_in == `OFS_FLAGS);

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wait_r  <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end else begin
            wait_r <= !(req && wait_r);
            if (req && wait_r && avs_read_in) begin
                unique case (avs_address_in)
                    `OFS_FLAGS:  rdata_r <= {24'h00_0000, flags_r};
                    `OFS_CTRL:   rdata_r <= {29'h0000_0000, bus_div_r, stop_en_r};
                    `OFS_STATUS: rdata_r <= {28'h000_0000, cpu_reset_r, gate_r, pin_oe_r, lv_sync_r};
                    default:     rdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign avs_readdata_out    = rdata_r;
    assign avs_waitrequest_out = wait_r;
    assign reset_pin_n_out     = pin_out_r;
    assign reset_pin_oe_out    = pin_oe_r;
    assign cpu_reset_out       = cpu_reset_r;
    assign clocks_gated_out    = gate_r;
    assign vector_fetch_out    = vfetch_r;
    assign vector_addr_out     = `RESET_VECTOR;
    assign bus_div_out         = bus_div_r;

    // run lengths count the closing edge too; oe_len_r saturates so a long brown-out cannot wrap it
    logic [12:0] oe_len_r, gate_len_r;
    logic        read_seen_r;

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            oe_len_r    <= 13'h0000;
            gate_len_r  <= 13'h0000;
            read_seen_r <= 1'b0;
        end else begin
            oe_len_r    <= !pin_oe_r ? 13'h0000 : (&oe_len_r ? oe_len_r : oe_len_r + 13'h0001);
            gate_len_r  <= gate_r ? gate_len_r + 13'h0001 : 13'h0000;
            read_seen_r <= read_seen_r || rd_clr;
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    sequence seq_pin_release;
        ##31 pin_oe_r ##1 !pin_oe_r;
    endsequence

    sequence seq_cpu_release;
        ##31 cpu_reset_r ##1 (!cpu_reset_r && vfetch_r);
    endsequence

    property p_stab_release;
        disable iff (sys_rst_in || lv_sync_r)
        $fell(gate_r) && state_r == s_drive |-> seq_pin_release ##0 seq_cpu_release;
    endproperty

    a_drive_length: assert property ($fell(pin_oe_r) && state_r == s_hold |-> oe_len_r >= 13'h0020)
        else $error("reset pin released before 32 cycles");
    a_hold_after: assert property ($fell(cpu_reset_r) && int_path_r |-> $past(pin_oe_r, 33) && !$past(pin_oe_r, 32))
        else $error("cpu released at wrong distance from pin release");
    a_stab_length: assert property ($fell(gate_r) && state_r == s_drive |-> gate_len_r == 13'h1000)
        else $error("stabilization delay not 4096 cycles");
    a_stab_pin: assert property (gate_r |-> pin_oe_r && cpu_reset_r)
        else $error("pin not driven during stabilization");
    a_stab_release: assert property (p_stab_release)
        else $error("pin or cpu release off after stabilization");
    a_por_flag: assert property (!read_seen_r |-> flags_r[`FLAG_POR])
        else $error("power-on flag lost without a read");
    a_lowv_drive: assert property (lv_sync_r |=> pin_oe_r && !gate_r && cpu_reset_r)
        else $error("low supply not driving the pin");
    a_lowv_flag: assert property (lv_entry |=> flags_r[`FLAG_LVI])
        else $error("low-voltage flag not set");
    a_wdog_flag: assert property (wdog_over |=> flags_r[`FLAG_WDOG] && pin_oe_r)
        else $error("watchdog overflow not logged");
    a_illegal_opcode_flag_flag: assert property (illegal_opcode_flag_evt |=> flags_r[`FLAG_ILLEGAL_OPCODE_FLAG] && pin_oe_r)
        else $error("illegal opcode not logged");
    a_illegal_address_flag_flag: assert property (illegal_address_flag_evt |=> flags_r[`FLAG_ILLEGAL_ADDRESS_FLAG])
        else $error("illegal address not logged");
    a_no_data_reset: assert property (state_r == s_run && !int_evt && !ext_evt && !lv_sync_r |=> !cpu_reset_r)
        else $error("reset without a source");
    a_read_clears: assert property (rd_clr |=> (flags_r & $past(rdata_r[7:0]) & ~$past(set_vec)) == 8'h00)
        else $error("read did not clear returned flags");
    a_accumulate: assert property (|($past(flags_r) & ~flags_r) |-> $past(rd_clr))
        else $error("flag dropped without a read");
    a_div_reset: assert property (cpu_reset_r |-> bus_div_r == div_by_4)
        else $error("bus clock not divide by four in reset");
    a_late_pin: assert property (late_pin |=> flags_r[`FLAG_PIN])
        else $error("late pin sample not logged");

    // source logging, abort and quiet paths
    a_mon_flag: assert property (mon_evt |=> flags_r[`FLAG_MON] && pin_oe_r)
        else $error("monitor entry not logged");
    a_ext_flag: assert property (ext_evt |=> flags_r[`FLAG_PIN] && cpu_reset_r)
        else $error("external reset not logged");
    a_ext_min: assert property (ext_evt |-> !$past(pin_sync_r, 3) && !$past(pin_sync_r))
        else $error("reset pin not low for the minimum time");
    a_abort_now: assert property (int_evt |=> cpu_reset_r)
        else $error("internal reset did not stop the cpu");
    a_vec_fetch: assert property (vfetch_r |-> !cpu_reset_r && $past(cpu_reset_r))
        else $error("vector fetch not at cpu release");
    a_wdog_kick: assert property (cpu_bus_in.data_write && cpu_bus_in.address == `WDOG_ADDR |=>
                                  wdog_cnt_r == 18'h0_0000)
        else $error("watchdog service did not clear the counter");
    a_data_quiet: assert property (!cpu_bus_in.opcode_fetch && !monitor_entry_in |->
                                   wdog_over || !int_evt)
        else $error("data access caused a reset");
    a_stop_allowed: assert property (stop_en_r && !cpu_bus_in.illegal_opcode |-> !illegal_opcode_flag_evt)
        else $error("enabled stop instruction caused a reset");

endmodule : reset_source_sequencer

// ===== sim/reset_pin_partner.sv
/* Outside device on the shared active-low reset pin; pulls it low on command.
   Assumes one oscillator clock; the line has a pull-up and reads high when free. */
module reset_pin_partner (
    // clock and command
    input  wire logic clock_in,
    input  wire logic pull_in,
    // device side of the open-drain pin
    input  wire logic dev_pin_n_in,
    input  wire logic dev_oe_in,
    // resolved pin level
    output logic      pin_n_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic pull_r = 1'b0;
    // whole-cycle pulls only, like a supervisor output
    always_ff @(posedge clock_in) begin
        pull_r <= pull_in;
    end
    // pull-up wins when nobody drives
    assign pin_n_out = (dev_oe_in ? dev_pin_n_in : 1'b1) & !pull_r;
endmodule : reset_pin_partner

// ===== sim/testbench.sv
/* Self-checking bench of reset_source_sequencer: bus tasks, cpu strobes, pin partner.
   Assumes the design files and reset_pin_partner are compiled first. */
`include "reset_seq_consts.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import reset_seq_pkg::*;
    logic        clock_in   = 1'b0;
    logic        sys_rst    = 1'b1;
    logic [3:0]  addr       = 4'h0;
    logic        rd         = 1'b0;
    logic        wr         = 1'b0;
    logic [31:0] wdata      = 32'h0000_0000;
    logic        pull       = 1'b0;
    logic        supply_low = 1'b0;
    logic        mon        = 1'b0;
    logic        kick_en    = 1'b0;
    cpu_bus_s    ev         = '0;
    cpu_bus_s    cpu_bus;
    logic [31:0] rdata, q;
    logic        waitreq, pin_n, dev_pin_n, pin_oe, cpu_rst, gated, vfetch;
    logic [15:0] vaddr;
    bus_div_e    div;
    int          num_errors = 0;
    int          checks     = 0;
    int          cyc        = 0;
    int          ng, n;
    int          fbit[5]    = '{`FLAG_ILLEGAL_OPCODE_FLAG, `FLAG_ILLEGAL_OPCODE_FLAG, `FLAG_ILLEGAL_ADDRESS_FLAG, `FLAG_MON, `FLAG_WDOG};

    always #50 clock_in = ~clock_in;
    always @(posedge clock_in) cyc <= cyc + 1;
    // watchdog service every 16 cycles, held off while a strobe is sent
    assign cpu_bus = (ev != '0) ? ev : (kick_en && cyc[3:0] == 4'h0) ?
                     cpu_bus_s'{data_write: 1'b1, address: `WDOG_ADDR, default: 0} : '0;

    reset_source_sequencer #(.WDOG_LIMIT(64)) uut (
        .clock_in(clock_in), .sys_rst_in(sys_rst), .avs_address_in(addr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
        .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq), .reset_pin_n_in(pin_n),
        .reset_pin_n_out(dev_pin_n), .reset_pin_oe_out(pin_oe), .supply_low_in(supply_low),
        .monitor_entry_in(mon), .cpu_bus_in(cpu_bus), .cpu_reset_out(cpu_rst),
        .clocks_gated_out(gated), .vector_fetch_out(vfetch), .vector_addr_out(vaddr),
        .bus_div_out(div));
    reset_pin_partner peer (.clock_in(clock_in), .pull_in(pull), .dev_pin_n_in(dev_pin_n),
        .dev_oe_in(pin_oe), .pin_n_out(pin_n));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic print_verdict();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict

    // request held until the rising edge that sees waitrequest low; data taken there
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clock_in);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do begin
            @(posedge clock_in);
            k++;
        end while (waitreq !== 1'b0 && k < 50);
        if (waitreq !== 1'b0) num_errors++;
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(q, e);
    endtask : rdchk

    task automatic fire(input int k);
        cpu_bus_s s;
        s = '0;
        s.address = 16'h0100;
        s.opcode_fetch = (k < 3);
        if (k == 0) s.illegal_opcode = 1'b1;
        if (k == 1) s.stop_opcode = 1'b1;
        if (k == 2) s.unmapped = 1'b1;
        @(posedge clock_in);
        if (k == 3) mon <= 1'b1;
        else if (k == 4) kick_en <= 1'b0;
        else ev <= s;
        @(posedge clock_in);
        mon <= 1'b0;
        ev <= '0;
    endtask : fire

    // phases: clocks gated, then pin driven, then cpu held, then release
    task automatic seq(output int g);
        int nb, nc, k;
        g = 0;
        nb = 0;
        nc = 0;
        k = 0;
        @(negedge clock_in);
        while (pin_oe !== 1'b1 && k < 500) begin
            @(negedge clock_in);
            k++;
        end
        chk(dev_pin_n, 1'b0);
        while (gated === 1'b1) begin
            @(negedge clock_in);
            g++;
        end
        while (pin_oe === 1'b1) begin
            @(negedge clock_in);
            nb++;
        end
        while (cpu_rst === 1'b1) begin
            @(negedge clock_in);
            nc++;
        end
        chk(nb, `DRIVE_CYCLES);
        chk(nc, `HOLD_CYCLES);
        chk({vfetch, vaddr}, {1'b1, `RESET_VECTOR});
        @(negedge clock_in);
        chk(vfetch, 1'b0);
        @(posedge clock_in);
    endtask : seq

    always @(posedge clock_in) begin
        if (cyc == 30000) begin
            num_errors++;
            print_verdict();
        end
    end

    initial begin
        repeat (8) @(posedge clock_in);
        chk({cpu_rst, gated, pin_oe, div}, {3'b111, div_by_4});
        sys_rst <= 1'b0;
        kick_en <= 1'b1;
        seq(ng);
        chk(ng >= 4094 && ng <= 4098, 1);
        rdchk(`OFS_FLAGS, `FLAGS_RST);
        bus(1'b1, `OFS_FLAGS, 32'h0000_00FF);
        rdchk(`OFS_FLAGS, 32'h0000_0000);
        rdchk(`OFS_CTRL, 32'h0000_0004);
        rdchk(4'hC, 32'h0000_0000);
        rdchk(`OFS_STATUS, 32'h0000_0000);
        // unmapped data write and a long serviced run: no reset
        ev <= cpu_bus_s'{data_write: 1'b1, unmapped: 1'b1, address: 16'h2000, default: 0};
        @(posedge clock_in);
        ev <= '0;
        repeat (200) @(posedge clock_in);
        chk(cpu_rst, 1'b0);
        bus(1'b1, `OFS_CTRL, 32'h0000_0001);
        fire(1);
        repeat (20) @(posedge clock_in);
        chk({cpu_rst, div}, {1'b0, div_by_1});
        for (int k = 0; k < 5; k++) begin
            bus(1'b1, `OFS_CTRL, 32'h0000_0000);
            fire(k);
            seq(ng);
            kick_en <= 1'b1;
            chk(div, div_by_4);
            rdchk(`OFS_FLAGS, 32'h1 << fbit[k]);
        end
        fire(0);
        seq(ng);
        fire(3);
        seq(ng);
        rdchk(`OFS_FLAGS, (32'h1 << `FLAG_ILLEGAL_OPCODE_FLAG) | (32'h1 << `FLAG_MON));
        pull <= 1'b1;
        repeat (10) @(posedge clock_in);
        chk(cpu_rst, 1'b1);
        pull <= 1'b0;
        repeat (80) @(posedge clock_in);
        rdchk(`OFS_FLAGS, 32'h1 << `FLAG_PIN);
        // pin held low by the partner past the device's own release
        fire(0);
        repeat (10) @(posedge clock_in);
        pull <= 1'b1;
        repeat (52) @(posedge clock_in);
        pull <= 1'b0;
        repeat (100) @(posedge clock_in);
        chk(cpu_rst, 1'b0);
        rdchk(`OFS_FLAGS, (32'h1 << `FLAG_ILLEGAL_OPCODE_FLAG) | (32'h1 << `FLAG_PIN));
        supply_low <= 1'b1;
        repeat (50) @(posedge clock_in);
        chk({pin_oe, gated, cpu_rst}, 3'b101);
        supply_low <= 1'b0;
        n = 0;
        while (gated !== 1'b1 && n < 20) begin
            @(negedge clock_in);
            n++;
        end
        seq(ng);
        chk(ng >= 4094 && ng <= 4098, 1);
        rdchk(`OFS_FLAGS, 32'h1 << `FLAG_LVI);
        fire(0);
        seq(ng);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock_in);
        sys_rst <= 1'b0;
        seq(ng);
        rdchk(`OFS_FLAGS, `FLAGS_RST);
        print_verdict();
    end
endmodule : testbench
